// ---- rtl/ctc_host_ctrl.sv ----
// Host controller driving the transceiver's transmit and standby pins
//
// Decided for this implementation: the placing of the registers and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
module ctc_host_ctrl
   import ctc_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire ctc_req_t req,
   output var logic [31:0] rdData,
   output var ctc_pins_t pins,
   input wire logic rxd
);

   // Address match used by the write and read paths
   function automatic logic hit(input logic [7:0] addr, input logic [7:0] reg_off);
      hit = (addr == reg_off);
   endfunction

   // Clamp a requested bit time into the legal window
   function automatic logic [15:0] clampPer(input logic [15:0] per);
      if (per > MAX_BIT_CYC)
         clampPer = MAX_BIT_CYC;
      else if (per < MIN_BIT_CYC)
         clampPer = MIN_BIT_CYC;
      else
         clampPer = per;
   endfunction

   logic standby;
   logic [15:0] bitPer;
   logic [7:0] txData;
   logic [7:0] rxData;
   logic wakeSeen;
   logic bitErr;
   ctc_txstate_t txState;
   logic [7:0] txShift;
   logic [7:0] rxShift;
   logic [3:0] bitCnt;
   logic [15:0] cycCnt;
   logic txd;
   logic wakePulse;

   logic next_standby;
   logic [15:0] next_bitPer;
   logic [7:0] next_txData;
   logic [7:0] next_rxData;
   logic next_wakeSeen;
   logic next_bitErr;
   ctc_txstate_t next_txState;
   logic [7:0] next_txShift;
   logic [7:0] next_rxShift;
   logic [3:0] next_bitCnt;
   logic [15:0] next_cycCnt;
   logic next_txd;
   logic [31:0] next_rdData;

   logic wrCtrl;
   logic wrStatus;
   logic startReq;
   logic samplePoint;
   logic bitEnd;
   logic errSet;
   logic [31:0] statusWord;

   // Wake-up detection runs only in Standby
   ctc_wake_mon u_wake
   (
      .mclk(mclk),
      .rst_n(rst_n),
      .standby(standby),
      .rxd(rxd),
      .wakePulse(wakePulse)
   );

   // Strobe decode and transmit timing points
   assign wrCtrl = req.wr && hit(req.addr, REG_CTRL);
   assign wrStatus = req.wr && hit(req.addr, REG_STATUS);
   // No frame starts unless the write also leaves Normal mode selected
   assign startReq = wrCtrl && req.wdata[CTRL_START_BIT] && !req.wdata[CTRL_STANDBY_BIT]
                     && !standby && (txState == TX_IDLE); // RL3
   assign samplePoint = (txState == TX_SEND) && (cycCnt == (bitPer >> 1));
   assign bitEnd = (txState == TX_SEND) && (cycCnt == bitPer - 16'h0001);
   assign errSet = samplePoint && (rxd != txd);

   // Status word seen by software
   always_comb
   begin
      statusWord = 32'h00000000;
      statusWord[STAT_STANDBY_BIT] = standby;
      statusWord[STAT_BUSY_BIT] = (txState == TX_SEND);
      statusWord[STAT_RXD_BIT] = rxd;
      statusWord[STAT_WAKE_BIT] = wakeSeen;
      statusWord[STAT_BITERR_BIT] = bitErr;
   end

   // Register file next values
   always_comb
   begin
      next_standby = standby;
      next_bitPer = bitPer;
      next_txData = txData;
      // Mode changes only on software order; a wake-up never flips it
      if (wrCtrl)
         next_standby = req.wdata[CTRL_STANDBY_BIT]; // RL1 RL8
      // Bit time capped so dominant runs of up to five bits end before the device time-out
      if (req.wr && hit(req.addr, REG_BITPER))
         next_bitPer = clampPer(req.wdata[15:0]); // RL12
      // Pattern is frozen during a frame to keep the shift consistent
      if (req.wr && hit(req.addr, REG_TXDATA) && (txState == TX_IDLE))
         next_txData = req.wdata[7:0];
      // Sticky flags: a set in the clearing cycle wins
      next_wakeSeen = (wakeSeen && !(wrStatus && req.wdata[STAT_WAKE_BIT])) || wakePulse; // RL7
      next_bitErr = (bitErr && !(wrStatus && req.wdata[STAT_BITERR_BIT])) || errSet;
   end

   // Read path: data stand only in the cycle after the strobe
   always_comb
   begin
      next_rdData = 32'h00000000;
      if (req.rd)
      begin
         if (hit(req.addr, REG_CTRL))
            next_rdData = {31'h00000000, standby};
         else if (hit(req.addr, REG_BITPER))
            next_rdData = {16'h0000, bitPer};
         else if (hit(req.addr, REG_TXDATA))
            next_rdData = {24'h000000, txData};
         else if (hit(req.addr, REG_STATUS))
            next_rdData = statusWord;
         else if (hit(req.addr, REG_RXDATA))
            next_rdData = {24'h000000, rxData};
      end
   end

   // Transmit engine next values
   always_comb
   begin
      next_txState = txState;
      next_txShift = txShift;
      next_rxShift = rxShift;
      next_bitCnt = bitCnt;
      next_cycCnt = cycCnt;
      next_txd = txd;
      next_rxData = rxData;
      unique case (txState)
         TX_IDLE:
         begin
            next_txd = 1'b1; // Recessive between frames
            if (startReq)
            begin
               next_txState = TX_SEND;
               next_txShift = txData;
               next_txd = txData[0];
               next_bitCnt = 4'h0;
               next_cycCnt = 16'h0000;
            end
         end
         TX_SEND:
         begin
            // Standby order aborts at once; the device cannot send anyway
            if (next_standby)
            begin
               next_txState = TX_IDLE; // RL3
               next_txd = 1'b1;
            end
            else
            begin
               next_cycCnt = cycCnt + 16'h0001;
               // Bus read back at mid-bit, LSB first
               if (samplePoint)
                  next_rxShift = {rxd, rxShift[7:1]}; // RL2
               if (bitEnd)
               begin
                  next_cycCnt = 16'h0000;
                  if (bitCnt == TX_BITS - 4'h1)
                  begin
                     next_txState = TX_IDLE;
                     next_txd = 1'b1; // RL11
                     next_rxData = rxShift;
                  end
                  else
                  begin
                     next_bitCnt = bitCnt + 4'h1;
                     next_txShift = {1'b1, txShift[7:1]};
                     next_txd = txShift[1]; // RL9
                  end
               end
            end
         end
      endcase
   end

   // Registers only; reset leaves pins recessive and Standby selected
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         standby <= CTRL_STANDBY_RST; // RL16
         bitPer <= BITPER_RST;
         txData <= TXDATA_RST;
         rxData <= RXDATA_RST;
         wakeSeen <= 1'b0;
         bitErr <= 1'b0;
         txState <= TX_IDLE;
         txShift <= TXDATA_RST;
         rxShift <= RXDATA_RST;
         bitCnt <= 4'h0;
         cycCnt <= 16'h0000;
         txd <= 1'b1;
         rdData <= 32'h00000000;
      end
      else
      begin
         standby <= next_standby;
         bitPer <= next_bitPer;
         txData <= next_txData;
         rxData <= next_rxData;
         wakeSeen <= next_wakeSeen;
         bitErr <= next_bitErr;
         txState <= next_txState;
         txShift <= next_txShift;
         rxShift <= next_rxShift;
         bitCnt <= next_bitCnt;
         cycCnt <= next_cycCnt;
         txd <= next_txd;
         rdData <= next_rdData;
      end
   end

   // Pins come straight from flip-flops
   always_comb
   begin
      pins.txd = txd;
      pins.standbySel = standby; // RL1 RL3
   end

endmodule
`default_nettype wire

// ---- include/ctc_pkg.sv ----
// Constants, register map and carrier types of the transceiver host controller
// Behaviour
// RL1 - Standby select low gives Normal mode
// RL2 - Normal mode: receive line mirrors bus state
// RL3 - Standby select high gives Standby, no transmission
// RL4 - Standby switches off transmitter and receiver
// RL5 - Standby biases bus lines toward ground
// RL6 - Standby receive line shows filtered bus state
// RL7 - Standby receive low means wake-up detected
// RL8 - Wake-up alone never returns to Normal
// RL9 - Transmit low starts dominant time-out timer
// RL10 - Transmit low too long disables transmitter
// RL11 - Transmit high clears dominant time-out timer
// RL12 - Controller keeps bit rate at least 40 kbit/s
// RL13 - Standby recessive-to-dominant starts bus timer
// RL14 - Bus dominant too long forces receive high
// RL15 - Bus dominant-to-recessive clears bus timer
// RL16 - Undriven transmit and standby inputs default high
// RL17 - Supply undervoltage forces Standby, ignores select
// RL18 - I/O undervoltage switches device fully off
// RL19 - Over-temperature disables drivers until cool, recessive
// RL20 - Split output driven in Normal, floating otherwise
// RL21 - Device time-outs are parameterised cycle counts
// RL22 - After time-out, transmitter waits for transmit high
// RL23 - Without I/O supply, I/O equals main supply
package ctc_pkg;

   // Register byte offsets on the software port
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_BITPER = 8'h04;
   localparam logic [7:0] REG_TXDATA = 8'h08;
   localparam logic [7:0] REG_STATUS = 8'h0C;
   localparam logic [7:0] REG_RXDATA = 8'h10;

   // Control register fields
   localparam int CTRL_STANDBY_BIT = 0;
   localparam int CTRL_START_BIT = 1;

   // Status register fields
   localparam int STAT_STANDBY_BIT = 0;
   localparam int STAT_BUSY_BIT = 1;
   localparam int STAT_RXD_BIT = 2;
   localparam int STAT_WAKE_BIT = 3;
   localparam int STAT_BITERR_BIT = 4;

   // Values after reset
   localparam logic CTRL_STANDBY_RST = 1'b1;
   localparam logic [15:0] BITPER_RST = 16'h007D;
   localparam logic [7:0] TXDATA_RST = 8'hFF;
   localparam logic [7:0] RXDATA_RST = 8'hFF;

   // Timing
   localparam int CLK_HZ = 125000000;
   localparam int CLK_PERIOD_NS = 8;
   localparam int MIN_BIT_RATE_BPS = 40000;
   // Longest bit time: rounds down
   localparam logic [15:0] MAX_BIT_CYC = 16'(CLK_HZ / MIN_BIT_RATE_BPS);
   // Shortest bit time keeps a distinct mid-bit sample point
   localparam logic [15:0] MIN_BIT_CYC = 16'h0004;
   localparam int WAKE_CONFIRM_NS = 1000;
   // Least time: rounds up
   localparam logic [7:0] WAKE_CYC = 8'((WAKE_CONFIRM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [3:0] TX_BITS = 4'h8;

   // Software port request
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [31:0] wdata;
   } ctc_req_t;

   // Pins driven toward the transceiver
   typedef struct packed {
      logic txd;
      logic standbySel;
   } ctc_pins_t;

   typedef enum logic [0:0] {TX_IDLE, TX_SEND} ctc_txstate_t;

endpackage

// ---- rtl/ctc_wake_mon.sv ----
// Wake-up request monitor on the receive line while in Standby
`timescale 1ns/100ps
`default_nettype none
module ctc_wake_mon
   import ctc_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic standby,
   input wire logic rxd,
   output var logic wakePulse
);

   logic [7:0] lowCnt;
   logic fired;
   logic [7:0] next_lowCnt;
   logic next_fired;
   logic next_wakePulse;

   // Low receive line in Standby means wake-up; confirm it to ride out glitches
   always_comb
   begin
      next_lowCnt = lowCnt;
      next_fired = fired;
      next_wakePulse = 1'b0;
      if (!standby || rxd) // RL7
      begin
         next_lowCnt = 8'h00;
         next_fired = 1'b0;
      end
      else if (!fired)
      begin
         if (lowCnt == WAKE_CYC - 8'h01)
         begin
            next_wakePulse = 1'b1; // One pulse per low episode
            next_fired = 1'b1;
         end
         else
            next_lowCnt = lowCnt + 8'h01;
      end
   end

   // Register the monitor state
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         lowCnt <= 8'h00;
         fired <= 1'b0;
         wakePulse <= 1'b0;
      end
      else
      begin
         lowCnt <= next_lowCnt;
         fired <= next_fired;
         wakePulse <= next_wakePulse;
      end
   end

endmodule
`default_nettype wire

// ---- tb/ctc_host_ctrl_props.sv ----
// Checker of the host controller's pins and read port
`timescale 1ns/100ps
`default_nettype none
module ctc_host_ctrl_props
   import ctc_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire ctc_req_t req,
   input wire logic [31:0] rdData,
   input wire ctc_pins_t pins,
   input wire logic rxd
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   logic [15:0] lowRun;
   // Length of the current dominant stretch on transmit data
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         lowRun <= 16'h0000;
      else
         lowRun <= pins.txd ? 16'h0000 : lowRun + 16'h0001;
   end
   a_select_follows: assert property (
      req.wr && req.addr == REG_CTRL |=> pins.standbySel == $past(req.wdata[CTRL_STANDBY_BIT]))
      else $error("standby select differs from written control bit");
   a_wake_keeps_standby: assert property (
      pins.standbySel && !(req.wr && req.addr == REG_CTRL) |=> pins.standbySel)
      else $error("standby left without a control write");
   a_standby_no_tx: assert property (
      pins.standbySel |-> pins.txd)
      else $error("transmit data dominant in standby");
   a_bit_rate_min: assert property (
      lowRun <= 16'h61A8)
      else $error("dominant stretch longer than eight slowest bits");
   a_read_one_cycle: assert property (
      !req.rd |=> rdData == 32'h0)
      else $error("read data outside the cycle after a read");
endmodule
bind ctc_host_ctrl ctc_host_ctrl_props ctc_host_ctrl_props_inst (.mclk(mclk), .rst_n(rst_n), .req(req),
   .rdData(rdData), .pins(pins), .rxd(rxd));
`default_nettype wire

// ---- tb/ctc_xcvr_model.sv ----
// Behavioural transceiver facing the host controller
`timescale 1ns/100ps
`default_nettype none
module ctc_xcvr_model #(
   parameter int TXTO = 16000,
   parameter int FLT = 16,
   parameter int BUSTO = 400,
   // Zero models the variant whose I/O levels come from the main supply
   parameter bit HAS_IO = 1'b1
)
(
   input wire logic mclk,
   input wire logic txd,
   input wire logic standbySel,
   input wire logic busForce,
   input wire logic mainSupplyOk,
   input wire logic ioSupplyOk,
   input wire logic overTemp,
   output logic rxd,
   output logic busBiasGnd,
   output logic splitDrive
);
   int txLow = 0;
   int domRun = 0;
   int filt = 0;
   logic txOff = 1'b0;
   logic drvOff = 1'b0;
   logic rxF = 1'b1;
   logic txdIn;
   logic sbyIn;
   logic ioOk;
   logic standby;
   logic busDom;
   // Pull-ups: a pin not driven low reads high
   assign txdIn = (txd !== 1'b0);
   assign sbyIn = (standbySel !== 1'b0);
   assign ioOk = HAS_IO ? ioSupplyOk : mainSupplyOk;
   // Low main supply forces Standby whatever the select pin says
   assign standby = sbyIn || !mainSupplyOk;
   // Own transmitter only in powered, cool Normal and before its time-out
   assign busDom = busForce || (ioOk && !standby && !txdIn && !txOff && !drvOff);
   // Standby shows only the filtered state, cut by the bus time-out; unpowered reads high
   assign rxd = !ioOk || (standby ? (rxF || domRun > BUSTO) : !busDom);
   // Bus biased to ground in Standby or off; split driven only in powered Normal
   assign busBiasGnd = standby || !ioOk;
   assign splitDrive = !standby && ioOk;
   // Time-outs and wake filter; short glitches never reach the host in Standby
   always @(posedge mclk)
   begin
      txLow <= txdIn ? 0 : txLow + 1;
      txOff <= txdIn ? 1'b0 : (txOff || txLow >= TXTO);
      // Heat keeps drivers off until cool with recessive transmit data, so no oscillation
      drvOff <= overTemp || (drvOff && !txdIn);
      domRun <= (standby && busDom) ? domRun + 1 : 0;
      filt <= (!busDom == rxF) ? 0 : filt + 1;
      if (!busDom != rxF && filt >= FLT)
         rxF <= !busDom;
   end
endmodule
`default_nettype wire

// ---- tb/ctc_host_ctrl_bench.sv ----
// Self-checking bench of the host controller with a transceiver model
`timescale 1ns/100ps
`default_nettype none
module ctc_host_ctrl_bench
   import ctc_pkg::*;
;
   typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] e;} ctc_row_t;
   logic mclk = 1'b0;
   logic rst_n;
   ctc_req_t req = '0;
   logic [31:0] rdData;
   ctc_pins_t pins;
   logic rxd;
   logic busForce = 1'b0;
   logic mainOk = 1'b1;
   logic ioOk = 1'b1;
   logic hot = 1'b0;
   logic biasGnd;
   logic splitOn;
   int bad_count = 0;
   int checks = 0;
   logic [31:0] d;
   logic [7:0] pat = 8'hA5;
   ctc_row_t rows [7] = '{'{REG_BITPER, 32'h2, 32'h4}, '{REG_BITPER, 32'hFFFF, 32'hC35},
      '{REG_TXDATA, 32'h1A5, 32'hA5}, '{REG_CTRL, 32'h0, 32'h0}, '{REG_CTRL, 32'h1, 32'h1},
      '{8'h14, 32'hFF, 32'h0}, '{REG_BITPER, 32'h8, 32'h8}};
   always #4 mclk = ~mclk;
   ctc_host_ctrl ctc_host_ctrl_inst (.mclk(mclk), .rst_n(rst_n), .req(req), .rdData(rdData),
      .pins(pins), .rxd(rxd));
   ctc_xcvr_model ctc_xcvr_model_inst (.mclk(mclk), .txd(pins.txd), .standbySel(pins.standbySel),
      .busForce(busForce), .mainSupplyOk(mainOk), .ioSupplyOk(ioOk), .overTemp(hot), .rxd(rxd),
      .busBiasGnd(biasGnd), .splitDrive(splitOn));
   task automatic wr(input logic [7:0] a, input logic [31:0] w);
      req <= '{1'b1, 1'b0, a, w};
      @(posedge mclk);
      req <= '0;
      #1;
   endtask
   task automatic rd(input logic [7:0] a);
      req <= '{1'b0, 1'b1, a, 32'h0};
      @(posedge mclk);
      req <= '0;
      #1;
      d = rdData;
   endtask
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e)
      begin
         $display("[FAIL] %s expected %h seen %h", n, e, s);
         bad_count++;
      end
   endtask
   task automatic final_report();
      $display("checks %0d bad_count %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Bounded poll until the frame engine is idle
   task automatic wait_idle();
      int n;
      n = 0;
      do
      begin
         rd(REG_STATUS);
         n++;
      end
      while (d[STAT_BUSY_BIT] !== 1'b0 && n < 300);
      if (d[STAT_BUSY_BIT] !== 1'b0)
      begin
         bad_count++;
         final_report();
      end
   endtask
   // Main sequence: rows first, then frames, wake and reset
   initial
   begin
      rst_n = 1'b0;
      repeat (10) @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      #1;
      foreach (rows[i])
      begin
         wr(rows[i].a, rows[i].w);
         rd(rows[i].a);
         chk("row", d, rows[i].e);
      end
      // Loopback frame in Normal, bits sampled mid-bit
      wr(REG_CTRL, 32'h0);
      wr(REG_CTRL, 32'h2);
      for (int b = 0; b < 8; b++)
      begin
         repeat (4) @(posedge mclk);
         #1;
         chk("txbit", {31'h0, pins.txd}, {31'h0, pat[b]});
         repeat (4) @(posedge mclk);
      end
      wait_idle();
      rd(REG_RXDATA);
      chk("rxdata", d, 32'hA5);
      // Bus held dominant by another node gives a bit error
      wr(REG_TXDATA, 32'hFF);
      busForce <= 1'b1;
      wr(REG_CTRL, 32'h2);
      wait_idle();
      busForce <= 1'b0;
      chk("biterr", {31'h0, d[STAT_BITERR_BIT]}, 32'h1);
      rd(REG_RXDATA);
      chk("rxforced", d, 32'h0);
      wr(REG_STATUS, 32'h10);
      rd(REG_STATUS);
      chk("biterrclr", {31'h0, d[STAT_BITERR_BIT]}, 32'h0);
      // Low supply, dead I/O supply and heat each keep a dominant frame off the bus
      wr(REG_TXDATA, 32'h0);
      for (int f = 0; f < 3; f++)
      begin
         mainOk <= (f != 0);
         ioOk <= (f != 1);
         hot <= (f == 2);
         wr(REG_CTRL, 32'h2);
         chk("faultPins", {30'h0, biasGnd, splitOn}, (f == 2) ? 32'h1 : 32'h2);
         wait_idle();
         chk("faultErr", {31'h0, d[STAT_BITERR_BIT]}, 32'h1);
         wr(REG_STATUS, 32'h10);
      end
      mainOk <= 1'b1;
      ioOk <= 1'b1;
      hot <= 1'b0;
      // Abort mid-frame and refused start in standby
      wr(REG_CTRL, 32'h2);
      repeat (10) @(posedge mclk);
      #1;
      chk("midframe", {30'h0, pins}, 32'h0);
      wr(REG_CTRL, 32'h1);
      chk("abort", {30'h0, pins}, 32'h3);
      rd(REG_STATUS);
      chk("abortIdle", {31'h0, d[STAT_BUSY_BIT]}, 32'h0);
      wr(REG_CTRL, 32'h3);
      repeat (3) @(posedge mclk);
      #1;
      chk("refused", {30'h0, pins}, 32'h3);
      // Short glitch must not wake, long dominant must
      busForce <= 1'b1;
      repeat (10) @(posedge mclk);
      busForce <= 1'b0;
      repeat (30) @(posedge mclk);
      rd(REG_STATUS);
      chk("nowake", {31'h0, d[STAT_WAKE_BIT]}, 32'h0);
      busForce <= 1'b1;
      repeat (200) @(posedge mclk);
      busForce <= 1'b0;
      repeat (30) @(posedge mclk);
      rd(REG_STATUS);
      chk("wake", {31'h0, d[STAT_WAKE_BIT]}, 32'h1);
      chk("stayStandby", {31'h0, pins.standbySel}, 32'h1);
      // Clamped dominant bus: flag cleared, then the device lets the receive line go high
      wr(REG_STATUS, 32'h8);
      rd(REG_STATUS);
      chk("wakeclr", {31'h0, d[STAT_WAKE_BIT]}, 32'h0);
      busForce <= 1'b1;
      repeat (450) @(posedge mclk);
      rd(REG_STATUS);
      chk("busTimeout", {31'h0, d[STAT_RXD_BIT]}, 32'h1);
      busForce <= 1'b0;
      // Let the wake filter settle before the reset
      repeat (30) @(posedge mclk);
      // Mid-run reset restores the defaults
      rst_n <= 1'b0;
      repeat (3) @(posedge mclk);
      chk("rstpins", {30'h0, pins}, 32'h3);
      rst_n <= 1'b1;
      @(posedge mclk);
      #1;
      rd(REG_BITPER);
      chk("bitper", d, 32'h7D);
      rd(REG_TXDATA);
      chk("txdata", d, 32'hFF);
      rd(REG_CTRL);
      chk("ctrl", d, 32'h1);
      rd(REG_STATUS);
      chk("statusrst", d, 32'h5);
      rd(REG_RXDATA);
      chk("rxdatarst", d, 32'hFF);
      final_report();
   end
endmodule
`default_nettype wire
